//--- src/itb_map.svh
// register map, field positions, reset values and timing figures of the interval timer
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

`define ITB_CLK_PERIOD_NS   40
`define ITB_ADDR_W          32
`define ITB_DATA_W          32

`define ITB_MODE_ADDR       32'hFFFFF8B0
`define ITB_CMP_ADDR        32'hFFFFF8B4
`define ITB_STAT_ADDR       32'hFFFFF8B8

`define ITB_MODE_RESET      8'h00
`define ITB_CMP_RESET       8'h00
`define ITB_MODE_WMASK      8'h17
`define ITB_RUN_BIT         4
`define ITB_WDIS_BIT        2
`define ITB_SEL_MSB         1
`define ITB_SEL_LSB         0

`define ITB_CNT_RELOAD      8'h01
`define ITB_CMP_ONCE        8'h01
`define ITB_CMP_FULL        8'h00
`define ITB_CNT_TOP         8'hFF
`define ITB_PRE_W           3

`define ITB_RESP_OKAY       2'h0
`define ITB_RESP_SLVERR     2'h2

`endif

//--- src/itb_pkg.sv
// types shared by the interval timer
package itb_pkg;

    typedef enum logic [1:0]
    {
        ITB_SEL_DIV1,
        ITB_SEL_DIV2,
        ITB_SEL_DIV4,
        ITB_SEL_DIV8
    } itb_sel_t;

    typedef struct packed
    {
        logic [2:0] zero_hi;
        logic       run;
        logic       zero_mid;
        logic       wdis;
        itb_sel_t   sel;
    } itb_mode_t;

    typedef struct packed
    {
        logic       once_done;
        logic       watch_level;
        logic [7:0] count;
    } itb_status_t;

endpackage : itb_pkg

//--- src/itb_timer.sv
// interval timer with watch timer count clock output, axi4-lite register slave
`timescale 1ns/10ps
`include "itb_map.svh"

module itb_timer
    import itb_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // axi4-lite write address
    input  wire logic [`ITB_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // axi4-lite write data
    input  wire logic [`ITB_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read address
    input  wire logic [`ITB_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // axi4-lite read data
    output logic [`ITB_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // timer outputs
    output logic                          interval_interrupt_request,
    output logic                          watch_count_clock
);

    // register state
    itb_mode_t              interval_mode_control;
    logic [7:0]             interval_compare_value;
    logic [`ITB_PRE_W-1:0]  prescaler;
    logic [7:0]             counter;
    logic                   once_done;

    // write channel holding state
    logic                   aw_held;
    logic                   w_held;
    logic [`ITB_ADDR_W-1:0] aw_addr_q;
    logic [7:0]             w_byte_q;
    logic                   w_lane0_q;

    // count clock enable from the prescaler for the given select value
    function automatic logic sel_tick(input itb_sel_t sel, input logic [`ITB_PRE_W-1:0] pre);
        case (sel)
            ITB_SEL_DIV1: sel_tick = 1'b1;
            ITB_SEL_DIV2: sel_tick = pre[0];
            ITB_SEL_DIV4: sel_tick = &pre[1:0];
            ITB_SEL_DIV8: sel_tick = &pre;
            default:      sel_tick = 1'b1;
        endcase
    endfunction : sel_tick

    // true when an address lands on one of the three registers
    function automatic logic addr_mapped(input logic [`ITB_ADDR_W-1:0] a);
        addr_mapped = (a == `ITB_MODE_ADDR) || (a == `ITB_CMP_ADDR) || (a == `ITB_STAT_ADDR);
    endfunction : addr_mapped

    // decode
    wire logic        run        = interval_mode_control.run;
    wire logic        wdis       = interval_mode_control.wdis;
    wire logic        tick       = run && sel_tick(interval_mode_control.sel, prescaler);
    wire logic        match      = (counter == interval_compare_value);
    wire logic        cmp_once   = (interval_compare_value == `ITB_CMP_ONCE);
    wire logic        hit        = tick && match;
    wire logic        fire       = hit && !(cmp_once && once_done);
    wire logic        wr_go      = aw_held && w_held && !s_axi_bvalid;
    wire logic        wr_ok      = wr_go && addr_mapped(aw_addr_q);
    wire logic        wr_mode    = wr_go && w_lane0_q && (aw_addr_q == `ITB_MODE_ADDR);
    wire logic        wr_cmp     = wr_go && w_lane0_q && (aw_addr_q == `ITB_CMP_ADDR);
    wire logic        rd_take    = s_axi_arvalid && s_axi_arready;
    wire logic        rd_ok      = addr_mapped(s_axi_araddr);
    wire itb_status_t status     = '{once_done: once_done, watch_level: watch_count_clock, count: counter};
    wire logic [7:0]  next_mode  = w_byte_q & `ITB_MODE_WMASK;
    wire logic [7:0]  next_count = hit ? `ITB_CNT_RELOAD : counter + 8'h01;
    wire logic [`ITB_DATA_W-1:0] rd_word =
        (s_axi_araddr == `ITB_MODE_ADDR) ? {24'h000000, interval_mode_control} :
        (s_axi_araddr == `ITB_CMP_ADDR)  ? {24'h000000, interval_compare_value} :
        (s_axi_araddr == `ITB_STAT_ADDR) ? {22'h000000, status} : 32'h00000000;

    // write address and data are taken independently, answered once both are in
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_byte_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ITB_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held       <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held       <= 1'b1;
                w_byte_q     <= s_axi_wdata[7:0];
                w_lane0_q    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read: one cycle from address to data, address refused while data waits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ITB_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `ITB_RESP_OKAY : `ITB_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // registers; bit-wise writes arrive as read-modify-write of the whole byte lane
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interval_mode_control  <= `ITB_MODE_RESET;
            interval_compare_value <= `ITB_CMP_RESET;
        end
        else
        begin
            if (wr_mode)
                interval_mode_control <= next_mode;
            if (wr_cmp)
                interval_compare_value <= w_byte_q;
        end
    end

    // prescaler restarts from zero on every run so the first interval is exact
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prescaler <= 3'h0;
        else if (!run)
            prescaler <= 3'h0;
        else
            prescaler <= prescaler + 3'h1;
    end

    // counter, one-shot flag, interrupt pulse and watch clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter                    <= `ITB_CNT_RELOAD;
            once_done                  <= 1'b0;
            interval_interrupt_request <= 1'b0;
            watch_count_clock          <= 1'b0;
        end
        else if (!run)
        begin
            counter                    <= `ITB_CNT_RELOAD;
            once_done                  <= 1'b0;
            interval_interrupt_request <= 1'b0;
            watch_count_clock          <= 1'b0;
        end
        else
        begin
            if (tick)
                counter <= next_count;
            // the match sets the flag even if a compare write clears it the same cycle
            if (hit && cmp_once)
                once_done <= 1'b1;
            else if (wr_cmp)
                once_done <= 1'b0;
            interval_interrupt_request <= fire;
            if (wdis)
                watch_count_clock <= 1'b0;
            else if (hit)
                watch_count_clock <= !watch_count_clock;
        end
    end

    // checks

    chk_stop_holds_one: assert property (@(posedge clk) disable iff (!rst_n)
        !run |=> (counter == 8'h01))
        else $error("counter not held at 01H while stopped");

    chk_irq_on_match: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && counter == interval_compare_value && !cmp_once) |=> interval_interrupt_request)
        else $error("match did not raise the interval request");

    chk_reload_on_match: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && match && run) |=> (counter == 8'h01))
        else $error("counter not reloaded to 01H after a match");

    chk_mode_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
        (interval_mode_control.zero_hi == 3'h0) && !interval_mode_control.zero_mid)
        else $error("fixed-zero mode bits are set");

    chk_full_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (run && tick && interval_compare_value == 8'h00 && counter == 8'hFF)
        |=> (counter == 8'h00) && !interval_interrupt_request)
        else $error("compare 00H did not wrap through 00H");

    chk_once_only: assert property (@(posedge clk) disable iff (!rst_n)
        (cmp_once && once_done && run && $stable(interval_compare_value)) |=> !interval_interrupt_request)
        else $error("compare 01H raised the request more than once");

    chk_div4_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(run) && interval_mode_control.sel == ITB_SEL_DIV4) |-> !tick [*3] ##1 tick)
        else $error("divide-by-4 count clock spacing wrong");

    chk_div2_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        (run && tick && interval_mode_control.sel == ITB_SEL_DIV2 && $stable(interval_mode_control))
        |=> !tick ##1 (tick || !run))
        else $error("divide-by-2 count clock spacing wrong");

    chk_watch_low_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (!run || wdis) |=> !watch_count_clock)
        else $error("watch clock not low while stopped or withheld");

    chk_watch_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        (run && !wdis && tick && match) |=> (watch_count_clock != $past(watch_count_clock)))
        else $error("watch clock did not toggle on a match");

    chk_irq_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
        interval_interrupt_request |-> $past(run))
        else $error("interval request while stopped");

    chk_pre_clear: assert property (@(posedge clk) disable iff (!rst_n)
        !run |=> (prescaler == 3'h0))
        else $error("prescaler not cleared while stopped");

    chk_pre_step: assert property (@(posedge clk) disable iff (!rst_n)
        run |=> (prescaler == $past(prescaler) + 3'h1))
        else $error("prescaler did not advance while running");

    chk_div1_tick: assert property (@(posedge clk) disable iff (!rst_n)
        (run && interval_mode_control.sel == ITB_SEL_DIV1) |-> tick)
        else $error("undivided count clock missed a cycle");

    chk_div8_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(run) && interval_mode_control.sel == ITB_SEL_DIV8) |-> !tick [*7] ##1 (tick || !run))
        else $error("divide-by-8 count clock spacing wrong");

    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && !match) |=> (counter == $past(counter) + 8'h01))
        else $error("counter did not step on a count clock");

    chk_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (run && !tick) |=> $stable(counter))
        else $error("counter moved without a count clock");

    chk_irq_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        interval_interrupt_request |=> !interval_interrupt_request)
        else $error("interval request longer than one cycle");

    chk_irq_from_match: assert property (@(posedge clk) disable iff (!rst_n)
        interval_interrupt_request |-> $past(hit))
        else $error("interval request without a counted match");

    chk_mode_fields: assert property (@(posedge clk) disable iff (!rst_n)
        wr_mode |=> (run == $past(w_byte_q[`ITB_RUN_BIT])) && (wdis == $past(w_byte_q[`ITB_WDIS_BIT])))
        else $error("mode write landed in the wrong fields");

    chk_cmp_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cmp |=> (interval_compare_value == $past(w_byte_q)))
        else $error("compare write did not land");

    chk_lane_off: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_go && !w_lane0_q) |=> $stable(interval_mode_control) && $stable(interval_compare_value))
        else $error("write without byte lane 0 changed a register");

    chk_write_answer: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_axi_bvalid) |-> $past(aw_held) && $past(w_held))
        else $error("write answered before address and data were held");

    chk_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered in the next cycle");

    chk_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while a response waits");

endmodule : itb_timer

//--- dv/itb_watch_model.sv
// watch timer model that consumes the generated count clock and measures it
`timescale 1ns/10ps
module itb_watch_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // count clock from the interval timer
    input  wire logic        watch_count_clock,
    // what the watch timer saw
    output logic [15:0]      rises,
    output logic [15:0]      period
);
    logic        last_level;
    logic [15:0] since;

    // only rising edges advance a watch prescaler, so period runs edge to edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_level <= 1'b0;
            since      <= 16'h0000;
            rises      <= 16'h0000;
            period     <= 16'h0000;
        end
        else
        begin
            last_level <= watch_count_clock;
            since      <= (watch_count_clock && !last_level) ? 16'h0001 : since + 16'h0001;
            if (watch_count_clock && !last_level)
            begin
                rises  <= rises + 16'h0001;
                period <= since;
            end
        end
    end
endmodule : itb_watch_model

//--- dv/itb_timer_test.sv
// self-checking bench for the interval timer and its watch clock output
`timescale 1ns/10ps
`include "itb_map.svh"
module itb_timer_test;
    logic        clk;
    logic        rst_n;
    logic [31:0] s_axi_awaddr;
    logic [31:0] s_axi_wdata;
    logic [31:0] s_axi_araddr;
    logic [31:0] s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  s_axi_awprot;
    logic [2:0]  s_axi_arprot;
    logic [1:0]  s_axi_bresp;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        interval_interrupt_request;
    logic        watch_count_clock;
    logic [15:0] rises;
    logic [15:0] period;
    int          n_errors;
    int          total_checks;
    int          cycles;

    itb_timer u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .interval_interrupt_request, .watch_count_clock);
    itb_watch_model u_watch (.clk, .rst_n, .watch_count_clock, .rises, .period);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // hang guard: the whole sequence needs well under 10000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_read

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        chk("bresp", `ITB_RESP_OKAY, r);
    endtask : wr

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk("rresp", `ITB_RESP_OKAY, r);
        chk(what, exp, d);
    endtask : rd_chk

    // software order: select and disable first with run low, then run
    task automatic start(input logic [7:0] n, input logic [7:0] mode);
        wr(`ITB_CMP_ADDR, {24'h0, n});
        wr(`ITB_MODE_ADDR, {24'h0, mode});
        wr(`ITB_MODE_ADDR, {24'h0, mode | 8'h10});
    endtask : start

    task automatic stop_and_check();
        wr(`ITB_MODE_ADDR, 32'h0);
        // the level seen at the response edge was launched while run was still set
        @(posedge clk);
        chk("watch stopped", 32'h0, {31'h0, watch_count_clock});
        rd_chk("stopped count", `ITB_STAT_ADDR, 32'h001);
    endtask : stop_and_check

    task automatic window(input int n, output int irqs, output int highs);
        irqs = 0;
        highs = 0;
        repeat (n)
        begin
            @(posedge clk);
            irqs += interval_interrupt_request;
            highs += watch_count_clock;
        end
    endtask : window

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk("mode reset", `ITB_MODE_ADDR, 32'h0);
        rd_chk("compare reset", `ITB_CMP_ADDR, 32'h0);
        rd_chk("idle count", `ITB_STAT_ADDR, 32'h001);
        axi_read(32'hFFFFF8BC, d, r);
        chk("unmapped rresp", `ITB_RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        axi_write(32'hFFFFF8BC, 32'hFF, r);
        chk("unmapped bresp", `ITB_RESP_SLVERR, r);
        wr(`ITB_MODE_ADDR, 32'hEF);
        rd_chk("mode fields", `ITB_MODE_ADDR, 32'h07);
        wr(`ITB_CMP_ADDR, 32'h1A5);
        rd_chk("compare byte", `ITB_CMP_ADDR, 32'hA5);
        s_axi_wstrb <= 4'hE;
        wr(`ITB_CMP_ADDR, 32'h33);
        s_axi_wstrb <= 4'hF;
        rd_chk("lane off", `ITB_CMP_ADDR, 32'hA5);
        wr(`ITB_MODE_ADDR, 32'h0);
        $display("test reset_and_fields done");
    endtask : t_reset

    task automatic t_interval(input int m, input logic [7:0] n);
        int exp;
        int gap;
        logic [15:0] r0;
        exp = (1 << m) * ((n == 8'h00) ? 256 : n);
        start(n, m[7:0]);
        do @(posedge clk); while (!interval_interrupt_request);
        gap = 0;
        do
        begin
            @(posedge clk);
            gap++;
        end
        while (!interval_interrupt_request);
        chk("irq interval", exp, gap);
        r0 = rises;
        while (rises < r0 + 16'h0002)
            @(posedge clk);
        chk("watch period", 2 * exp, {16'h0, period});
        stop_and_check();
        $display("test interval m=%0d n=%0d done", m, n);
    endtask : t_interval

    // software derivation of compare value and select for a 32.768 kHz watch clock
    task automatic t_watch_setup(input int fx);
        int n;
        int m;
        n = (fx + 32768) / 65536;
        m = 0;
        while (n % 2 == 0 && m < 3)
        begin
            n = n / 2;
            m++;
        end
        t_interval(m, n[7:0]);
    endtask : t_watch_setup

    task automatic t_once();
        int irqs;
        int highs;
        start(8'h01, 8'h01);
        window(200, irqs, highs);
        chk("single irq", 1, irqs);
        stop_and_check();
        $display("test once done");
    endtask : t_once

    task automatic t_disable();
        int irqs;
        int highs;
        start(8'h03, 8'h04);
        window(99, irqs, highs);
        chk("watch withheld", 0, highs);
        chk("still counting", 1, {31'h0, irqs > 30});
        stop_and_check();
        $display("test disable done");
    endtask : t_disable

    initial
    begin
        rst_n = 1'b0;
        s_axi_awaddr = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_araddr = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        for (int m = 0; m < 4; m++)
            t_interval(m, 8'h05);
        t_interval(0, 8'h00);
        t_once();
        t_disable();
        t_watch_setup(8000000);
        complete_run();
    end
endmodule : itb_timer_test
